//--- sim/tcd_dma_properties.sv
// Concurrent checks on the ports of the DMA register block
`timescale 1ns/10ps
module tcd_dma_properties
    import tcd_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic nmi_take,
    input wire logic [1:0] dreq_n,
    input wire logic [7:0] bus_rdata,
    input wire tcd_bus_t bus_out,
    input wire logic bus_hold,
    input wire logic tend0_n,
    input wire logic [1:0] irq
);
    default clocking dclk @(posedge mclk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    sequence st_ch0_irq_enable_on;
        io_wr && io_addr == 8'h30 && !io_wdata[4] && !io_wdata[6] && io_wdata[2] ##1 !io_wr;
    endsequence
    sequence st_ch0_irq_enable_off;
        io_wr && io_addr == 8'h30 && !io_wdata[2] ##1 !io_wr;
    endsequence
    sequence nmi_quiet;
        nmi_take && !bus_hold && !bus_out.rd ##1 !io_wr [*3];
    endsequence
    ////////////////////////////////////////////////////////////////
    guard_read_a: assert property (io_rd && io_addr == 8'h30 |=>
        io_rdata[5:4] == 2'b11 && !io_rdata[1]) else $error("status guard bits misread");
    irq_raise_a: assert property (st_ch0_irq_enable_on |-> ##1 irq[0])
        else $error("irq not raised with enable low");
    irq_mask_a: assert property (st_ch0_irq_enable_off |-> ##1 !irq[0])
        else $error("irq raised while masked");
    rd_then_wr_a: assert property (bus_out.rd |=> bus_out.wr && !bus_out.rd)
        else $error("read cycle not followed by write cycle");
    wr_data_a: assert property (bus_out.rd ##1 bus_out.wr |->
        bus_out.wdata == $past(bus_rdata)) else $error("written byte differs from read byte");
    hold_bus_a: assert property (bus_out.rd || bus_out.wr |-> bus_hold)
        else $error("bus cycle without bus hold");
    tend_write_a: assert property (!tend0_n |-> bus_out.wr)
        else $error("end pulse outside write cycle");
    nmi_stop_a: assert property (nmi_quiet |-> !bus_out.rd)
        else $error("transfer started after nmi");
    reset_idle_a: assert property ($fell(srst) |-> !bus_hold && irq == 2'b00 && tend0_n
        && bus_out == '0) else $error("outputs not idle after reset");
endmodule
bind tcd_dma tcd_dma_properties tcd_dma_properties_inst (.mclk, .srst, .io_addr, .io_wr,
    .io_rd, .io_wdata, .io_rdata, .nmi_take, .dreq_n, .bus_rdata, .bus_out, .bus_hold,
    .tend0_n, .irq);

//--- sim/tcd_dma_tb_top.sv
// Self-checking bench for the DMA register block
`timescale 1ns/10ps
module tcd_dma_tb_top;
    import tcd_pkg::*;
    logic mclk, srst, io_wr, io_rd, nmi_take, bus_hold, tend0_n;
    logic [7:0] io_addr, io_wdata, io_rdata, bus_rdata, rv;
    logic [1:0] dreq_n, irq;
    tcd_bus_t bus_out;
    int err_count = 0, check_count = 0, cyc = 0, i;
    logic [23:0] rows [0:8] = '{24'h20a5a5, 24'h22ff0f, 24'h2cc3c3, 24'h2e7e7e, 24'h313e3e,
        24'h320c0c, 24'h300d3c, 24'h303f3c, 24'h40ff00};
    tcd_dma tcd_dma_inst (.mclk(mclk), .srst(srst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .nmi_take(nmi_take),
        .dreq_n(dreq_n), .bus_rdata(bus_rdata), .bus_out(bus_out), .bus_hold(bus_hold),
        .tend0_n(tend0_n), .irq(irq));
    tcd_mem_model tcd_mem_model_inst (.mclk(mclk), .bus_out(bus_out), .bus_rdata(bus_rdata));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("errors=%0d checks=%0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc > 3000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // Each access leaves one idle edge so strobes never toggle twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        tick(1);
        io_wr = 1'b0;
        tick(1);
    endtask
    // Status write that starts a transfer at once: no trailing idle edge
    task automatic kick(input logic [7:0] d);
        io_addr = 8'h30;
        io_wdata = d;
        io_wr = 1'b1;
        tick(1);
        io_wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        io_addr = a;
        io_rd = 1'b1;
        tick(1);
        io_rd = 1'b0;
        d = io_rdata;
        tick(1);
    endtask
    task automatic wr_n(input logic [7:0] a, input logic [23:0] v, input int n);
        for (int k = 0; k < n; k++) begin
            wr_reg(a + 8'(k), v[8*k +: 8]);
        end
    endtask
    // One byte moved: read cycle, write cycle, then bus ownership after it
    task automatic byte_chk(input logic [19:0] ra, input logic rio, input logic [19:0] wa,
            input logic wio, input logic stop, input logic hold_after);
        int n;
        n = 0;
        while (bus_out.rd !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        chk(bus_out.addr, ra);
        chk(bus_out.is_io, rio);
        tick(1);
        chk(bus_out.wr, 1'b1);
        chk(bus_out.addr, wa);
        chk(bus_out.is_io, wio);
        chk(bus_out.wdata, ra[7:0] ^ 8'h5a);
        if (stop) begin
            io_addr = 8'h30;
            io_wdata = 8'h10;
            io_wr = 1'b1;
        end
        tick(1);
        if (stop) begin
            io_wr = 1'b0;
        end
        chk(bus_hold, hold_after);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        io_addr = 8'h00;
        io_wdata = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        nmi_take = 1'b0;
        dreq_n = 2'b11;
        tick(8);
        srst = 1'b0;
        for (i = 0; i < 9; i++) begin
            wr_reg(rows[i][23:16], rows[i][15:8]);
            rd_reg(rows[i][23:16], rv);
            chk(rv, rows[i][7:0]);
        end
        chk(irq, 2'b11);
        srst = 1'b1;
        tick(3);
        srst = 1'b0;
        tick(1);
        chk(irq, 2'b00);
        rd_reg(8'h30, rv);
        chk(rv, 8'h30);
        rd_reg(8'h31, rv);
        chk(rv, 8'h00);
        rd_reg(8'h32, rv);
        chk(rv, 8'hf0);
        // Channel 0 memory to memory, cycle steal, both addresses up
        wr_n(8'h20, 24'h000100, 3);
        wr_n(8'h23, 24'h000200, 3);
        wr_n(8'h26, 24'h000002, 2);
        kick(8'h64);
        byte_chk(20'h00100, 1'b0, 20'h00200, 1'b0, 1'b0, 1'b0);
        byte_chk(20'h00101, 1'b0, 20'h00201, 1'b0, 1'b0, 1'b0);
        rd_reg(8'h30, rv);
        chk(rv, 8'h35);
        rd_reg(8'h26, rv);
        chk(rv, 8'h00);
        chk(irq[0], 1'b1);
        // Burst with source stepping down
        wr_n(8'h20, 24'h000110, 3);
        wr_n(8'h23, 24'h000200, 3);
        wr_n(8'h26, 24'h000002, 2);
        wr_reg(8'h31, 8'h06);
        kick(8'h64);
        byte_chk(20'h00110, 1'b0, 20'h00200, 1'b0, 1'b0, 1'b1);
        byte_chk(20'h0010f, 1'b0, 20'h00201, 1'b0, 1'b0, 1'b0);
        // I/O source paced by the request pin, burst bit ignored
        wr_reg(8'h32, 8'hf0);
        wr_n(8'h20, 24'h000077, 3);
        wr_n(8'h23, 24'h000500, 3);
        wr_n(8'h26, 24'h000002, 2);
        wr_reg(8'h31, 8'h1e);
        wr_reg(8'h30, 8'h64);
        tick(10);
        chk(bus_hold, 1'b0);
        dreq_n[0] = 1'b0;
        byte_chk(20'h00077, 1'b1, 20'h00500, 1'b0, 1'b0, 1'b1);
        byte_chk(20'h00077, 1'b1, 20'h004ff, 1'b0, 1'b0, 1'b0);
        dreq_n[0] = 1'b1;
        // Channel 1 I/O to memory, memory address down
        wr_reg(8'h32, 8'hf3);
        wr_n(8'h2b, 24'h001234, 2);
        wr_n(8'h28, 24'h000300, 3);
        wr_n(8'h2e, 24'h000002, 2);
        dreq_n[1] = 1'b0;
        wr_reg(8'h30, 8'h90);
        byte_chk(20'h01234, 1'b1, 20'h00300, 1'b0, 1'b0, 1'b1);
        byte_chk(20'h01234, 1'b1, 20'h002ff, 1'b0, 1'b0, 1'b0);
        dreq_n[1] = 1'b1;
        rd_reg(8'h30, rv);
        chk(rv[7], 1'b0);
        // Channel 1 memory to I/O: nmi, halt mid-run, resume
        wr_reg(8'h32, 8'hf0);
        wr_n(8'h28, 24'h000400, 3);
        wr_n(8'h2b, 24'h000055, 2);
        wr_n(8'h2e, 24'h000002, 2);
        wr_reg(8'h30, 8'h90);
        nmi_take = 1'b1;
        dreq_n[1] = 1'b0;
        tick(1);
        nmi_take = 1'b0;
        repeat (8) begin
            tick(1);
            chk(bus_hold, 1'b0);
        end
        rd_reg(8'h30, rv);
        chk(rv[0], 1'b0);
        kick(8'h90);
        byte_chk(20'h00400, 1'b0, 20'h00055, 1'b1, 1'b1, 1'b0);
        tick(6);
        chk(bus_hold, 1'b0);
        rd_reg(8'h2e, rv);
        chk(rv, 8'h01);
        kick(8'h90);
        byte_chk(20'h00401, 1'b0, 20'h00055, 1'b1, 1'b0, 1'b0);
        dreq_n[1] = 1'b1;
        rd_reg(8'h2e, rv);
        chk(rv, 8'h00);
        rd_reg(8'h30, rv);
        chk(rv[7], 1'b0);
        // Channel 0 edge-sensed request, I/O destination, one byte
        wr_reg(8'h32, 8'hf8);
        wr_n(8'h20, 24'h000600, 3);
        wr_n(8'h23, 24'h000042, 3);
        wr_n(8'h26, 24'h000001, 2);
        wr_reg(8'h31, 8'h30);
        wr_reg(8'h30, 8'h64);
        tick(4);
        chk(bus_hold, 1'b0);
        dreq_n[0] = 1'b0;
        byte_chk(20'h00600, 1'b0, 20'h00042, 1'b1, 1'b0, 1'b0);
        dreq_n[0] = 1'b1;
        rd_reg(8'h30, rv);
        chk(rv[6], 1'b0);
        wrap_up();
    end
endmodule

//--- sim/tcd_mem_model.sv
// Memory and I/O responder on the far side of the DMA bus
`timescale 1ns/10ps
module tcd_mem_model
    import tcd_pkg::*;
(
    input wire logic mclk,
    input wire tcd_bus_t bus_out,
    output logic [7:0] bus_rdata
);
    logic [7:0] last_reg;
    wire [7:0] fetch = bus_out.addr[7:0] ^ 8'h5a;
    // Released bus shows the inverse of the last byte
    assign bus_rdata = bus_out.rd ? fetch : ~last_reg;
    always_ff @(posedge mclk) begin
        if (bus_out.rd) begin
            last_reg <= fetch;
        end
    end
endmodule

//--- verilog/tcd_defs.svh
// Constants for the two-channel DMA register block
`ifndef TCD_DEFS_SVH
`define TCD_DEFS_SVH

`define TCD_AW 20
`define TCD_OFF_CH0_SOURCE_ADDRESS 8'h20
`define TCD_OFF_CH0_DEST_ADDRESS 8'h23
`define TCD_OFF_CH0_BYTE_COUNT 8'h26
`define TCD_OFF_CH1_MEMORY_ADDRESS 8'h28
`define TCD_OFF_CH1_IO_ADDRESS 8'h2b
`define TCD_OFF_CH1_BYTE_COUNT 8'h2e
`define TCD_OFF_STAT 8'h30
`define TCD_OFF_MODE 8'h31
`define TCD_OFF_WCTL 8'h32

`define TCD_ST_DE0 6
`define TCD_ST_CH0_ENABLE_WRITE_GUARD 4
`define TCD_ST_CH0_IRQ_ENABLE 2
`define TCD_ST_DME 0
`define TCD_MD_DM 4
`define TCD_MD_SM 2
`define TCD_MD_BURST 1
`define TCD_WC_SENSE_CH1 2
`define TCD_WC_SENSE_CH0 3

`define TCD_WCTL_RST 8'hf0
`define TCD_CNT_LAST 16'h0001

`endif

//--- verilog/tcd_dma.sv
// Two-channel DMA registers and byte mover
//
// Operation
// - 16-bit counts decrement per byte, end at zero
// - Channel 0 addresses: 20-bit memory or I/O
// - Channel 1 memory address, source or destination
// - Channel 1 16-bit I/O address register
// - Transfers need channel enable and master enable
// - Channel 1 end clears its enable bit
// - Channel 0 end clears its enable bit
// - Irq when enable low and irq-enable high
// - Enable written only with guard bit zero
// - Guard bits not stored, read as one
// - Guarded enable write of one sets master
// - Channel 1 disable keeps address and count
// - Non-maskable interrupt clears master enable
// - Master enable not directly writable
// - Reset clears enables, modes, burst bit
// - Destination mode: inc, dec, fixed, I/O
// - Source mode: inc, dec, fixed, I/O
// - Burst holds bus until count zero
// - Cycle steal yields one cycle per byte
// - I/O modes paced by request, burst ignored
// - Channel 1 mode: direction and step
// - Request sense level or falling edge
`timescale 1ns/10ps
`include "tcd_defs.svh"

module tcd_dma
    import tcd_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic nmi_take,
    input wire logic [1:0] dreq_n,
    input wire logic [7:0] bus_rdata,
    output tcd_bus_t bus_out,
    output logic bus_hold,
    output logic tend0_n,
    output logic [1:0] irq
);

    ////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [`TCD_AW-1:0] put_byte(
        input logic [`TCD_AW-1:0] v,
        input logic [7:0] off,
        input logic [7:0] b
    );
        logic [`TCD_AW-1:0] r;
        r = v;
        case (off[1:0])
            2'h0: r[7:0] = b;
            2'h1: r[15:8] = b;
            default: r[`TCD_AW-1:16] = b[`TCD_AW-17:0];
        endcase
        return r;
    endfunction

    // Address step: 00 up, 01 down, else fixed
    function automatic logic [`TCD_AW-1:0] step(
        input logic [`TCD_AW-1:0] v,
        input logic [1:0] mode
    );
        logic [`TCD_AW-1:0] r;
        r = v;
        case (mode)
            2'b00: r = v + `TCD_AW'(1);
            2'b01: r = v - `TCD_AW'(1);
            default: r = v;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Registers

    logic [`TCD_AW-1:0] sar_reg;
    logic [`TCD_AW-1:0] dar_reg;
    logic [`TCD_AW-1:0] mar_reg;
    logic [15:0] iar_reg;
    logic [15:0] cnt_reg [0:1];
    logic [1:0] en_reg;
    logic [1:0] ie_reg;
    logic dme_reg;
    logic [1:0] dm_reg;
    logic [1:0] sm_reg;
    logic burst_reg;
    logic [7:0] wctl_reg;
    tcd_state_t state_reg;
    tcd_state_t state_next;
    logic sel_reg;
    tcd_bus_t bus_reg;
    logic hold_reg;
    logic tend_n_reg;
    logic [1:0] irq_reg;
    logic [7:0] rdata_reg;

    ////////////////////////////////////////////////////////////////
    // Address decode

    wire [7:0] off_sar = io_addr - `TCD_OFF_CH0_SOURCE_ADDRESS;
    wire [7:0] off_dar = io_addr - `TCD_OFF_CH0_DEST_ADDRESS;
    wire [7:0] off_bc0 = io_addr - `TCD_OFF_CH0_BYTE_COUNT;
    wire [7:0] off_mar = io_addr - `TCD_OFF_CH1_MEMORY_ADDRESS;
    wire [7:0] off_iar = io_addr - `TCD_OFF_CH1_IO_ADDRESS;
    wire [7:0] off_bc1 = io_addr - `TCD_OFF_CH1_BYTE_COUNT;
    wire hit_sar = off_sar < 8'h03;
    wire hit_dar = off_dar < 8'h03;
    wire hit_bc0 = off_bc0 < 8'h02;
    wire hit_mar = off_mar < 8'h03;
    wire hit_iar = off_iar < 8'h02;
    wire hit_bc1 = off_bc1 < 8'h02;
    wire hit_stat = io_addr == `TCD_OFF_STAT;
    wire hit_mode = io_addr == `TCD_OFF_MODE;
    wire hit_wctl = io_addr == `TCD_OFF_WCTL;
    wire w_stat = io_wr & hit_stat;
    wire w_mode = io_wr & hit_mode;
    wire w_wctl = io_wr & hit_wctl;

    ////////////////////////////////////////////////////////////////
    // Mode decode

    wire ch0_src_io = sm_reg == 2'b11;
    wire ch0_dst_io = dm_reg == 2'b11;
    wire ch0_memmem = ~ch0_src_io & ~ch0_dst_io;
    wire ch1_io_to_mem = wctl_reg[1];
    wire ch1_dec = wctl_reg[0];
    wire [1:0] sense = {wctl_reg[`TCD_WC_SENSE_CH1],
                        wctl_reg[`TCD_WC_SENSE_CH0]};

    ////////////////////////////////////////////////////////////////
    // Request inputs: sync, edge detect, pending

    wire [1:0] req_ok;
    wire [1:0] take;

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_req
            logic sync1_reg;
            logic sync2_reg;
            logic prev_reg;
            logic pend_reg;
            wire sense_edge = c == 0 ? sense[0] : sense[1];
            wire fall = prev_reg & ~sync2_reg;
            assign req_ok[c] = sense_edge ? pend_reg : ~sync2_reg;
            always_ff @(posedge mclk) begin
                if (srst) begin
                    sync1_reg <= 1'b1;
                    sync2_reg <= 1'b1;
                    prev_reg <= 1'b1;
                    pend_reg <= 1'b0;
                end else begin
                    sync1_reg <= dreq_n[c];
                    sync2_reg <= sync1_reg;
                    prev_reg <= sync2_reg;
                    // New edge beats consumption
                    if (fall)
                        pend_reg <= 1'b1;
                    else if (take[c])
                        pend_reg <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // Enable and master enable

    wire in_write = state_reg == TCD_WRITE;
    wire [1:0] done;
    assign done[0] = in_write & ~sel_reg & (cnt_reg[0] == `TCD_CNT_LAST);
    assign done[1] = in_write & sel_reg & (cnt_reg[1] == `TCD_CNT_LAST);

    wire [1:0] guard_n = io_wdata[`TCD_ST_CH0_ENABLE_WRITE_GUARD+1:`TCD_ST_CH0_ENABLE_WRITE_GUARD];
    wire [1:0] en_wbit = io_wdata[`TCD_ST_DE0+1:`TCD_ST_DE0];
    wire [1:0] sw_en = {2{w_stat}} & ~guard_n;
    wire [1:0] en_next;
    assign en_next[0] = done[0] ? 1'b0 : (sw_en[0] ? en_wbit[0] : en_reg[0]);
    assign en_next[1] = done[1] ? 1'b0 : (sw_en[1] ? en_wbit[1] : en_reg[1]);
    wire dme_set = |(sw_en & en_wbit);
    wire dme_next = nmi_take ? 1'b0 : (dme_set ? 1'b1 : dme_reg);
    wire [1:0] go = en_next & {2{dme_next}};

    ////////////////////////////////////////////////////////////////
    // Sequencer

    wire start0 = go[0] & (ch0_memmem | req_ok[0]);
    wire start1 = go[1] & req_ok[1];
    // Burst and level pacing keep the bus
    wire pace0 = ch0_memmem ? burst_reg : req_ok[0];
    wire cont = sel_reg ? (go[1] & req_ok[1]) : (go[0] & pace0);
    wire from_idle = state_reg == TCD_IDLE;
    wire begin_rd = from_idle ? (start0 | start1) : (in_write & cont);
    wire nsel = from_idle ? ~start0 : sel_reg;
    assign take[0] = begin_rd & ~nsel & ~ch0_memmem;
    assign take[1] = begin_rd & nsel;

    always_comb begin
        case (state_reg)
            TCD_IDLE: state_next = begin_rd ? TCD_READ : TCD_IDLE;
            TCD_READ: state_next = TCD_WRITE;
            TCD_WRITE: state_next = begin_rd ? TCD_READ : TCD_IDLE;
            default: state_next = TCD_IDLE;
        endcase
    end

    // Source and destination of each byte
    wire [`TCD_AW-1:0] iar_ext = {{(`TCD_AW-16){1'b0}}, iar_reg};
    // Chained byte: source address as stepped on this edge
    wire [`TCD_AW-1:0] sar_now = (in_write & ~sel_reg) ? step(sar_reg, sm_reg) : sar_reg;
    wire [`TCD_AW-1:0] mar_now = (in_write & sel_reg) ? step(mar_reg, {1'b0, ch1_dec}) : mar_reg;
    wire [`TCD_AW-1:0] sar_out = ch0_src_io ? {{(`TCD_AW-16){1'b0}}, sar_now[15:0]} : sar_now;
    wire [`TCD_AW-1:0] dar_out = ch0_dst_io ? {{(`TCD_AW-16){1'b0}}, dar_reg[15:0]} : dar_reg;
    wire [`TCD_AW-1:0] src1 = ch1_io_to_mem ? iar_ext : mar_now;
    wire [`TCD_AW-1:0] dst1 = ch1_io_to_mem ? mar_reg : iar_ext;
    wire [`TCD_AW-1:0] src_addr = nsel ? src1 : sar_out;
    wire src_io = nsel ? ch1_io_to_mem : ch0_src_io;
    wire [`TCD_AW-1:0] dst_addr = sel_reg ? dst1 : dar_out;
    wire dst_io = sel_reg ? ~ch1_io_to_mem : ch0_dst_io;
    wire last0 = ~sel_reg & (cnt_reg[0] == `TCD_CNT_LAST);

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= TCD_IDLE;
            sel_reg <= 1'b0;
            hold_reg <= 1'b0;
            tend_n_reg <= 1'b1;
            bus_reg <= '0;
        end else begin
            state_reg <= state_next;
            sel_reg <= nsel;
            hold_reg <= state_next != TCD_IDLE;
            tend_n_reg <= ~(state_reg == TCD_READ & last0);
            bus_reg.rd <= begin_rd;
            bus_reg.wr <= state_reg == TCD_READ;
            if (begin_rd) begin
                bus_reg.addr <= src_addr;
                bus_reg.is_io <= src_io;
            end else if (state_reg == TCD_READ) begin
                bus_reg.addr <= dst_addr;
                bus_reg.is_io <= dst_io;
                bus_reg.wdata <= bus_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Software-writable registers

    wire step0 = in_write & ~sel_reg;
    wire step1 = in_write & sel_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            sar_reg <= '0;
            dar_reg <= '0;
        end else begin
            if (io_wr & hit_sar)
                sar_reg <= put_byte(sar_reg, off_sar, io_wdata);
            else if (step0)
                sar_reg <= step(sar_reg, sm_reg);
            if (io_wr & hit_dar)
                dar_reg <= put_byte(dar_reg, off_dar, io_wdata);
            else if (step0)
                dar_reg <= step(dar_reg, dm_reg);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mar_reg <= '0;
            iar_reg <= '0;
        end else begin
            if (io_wr & hit_mar)
                mar_reg <= put_byte(mar_reg, off_mar, io_wdata);
            else if (step1)
                mar_reg <= step(mar_reg, {1'b0, ch1_dec});
            if (io_wr & hit_iar)
                iar_reg <= 16'(put_byte(iar_ext, off_iar, io_wdata));
        end
    end

    wire [`TCD_AW-1:0] bc0_ext = {{(`TCD_AW-16){1'b0}}, cnt_reg[0]};
    wire [`TCD_AW-1:0] bc1_ext = {{(`TCD_AW-16){1'b0}}, cnt_reg[1]};

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_reg[0] <= '0;
            cnt_reg[1] <= '0;
        end else begin
            if (io_wr & hit_bc0)
                cnt_reg[0] <= 16'(put_byte(bc0_ext, off_bc0, io_wdata));
            else if (step0)
                cnt_reg[0] <= cnt_reg[0] - 16'h0001;
            if (io_wr & hit_bc1)
                cnt_reg[1] <= 16'(put_byte(bc1_ext, off_bc1, io_wdata));
            else if (step1)
                cnt_reg[1] <= cnt_reg[1] - 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            en_reg <= 2'b00;
            ie_reg <= 2'b00;
            dme_reg <= 1'b0;
        end else begin
            en_reg <= en_next;
            dme_reg <= dme_next;
            if (w_stat)
                ie_reg <= io_wdata[`TCD_ST_CH0_IRQ_ENABLE+1:`TCD_ST_CH0_IRQ_ENABLE];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            dm_reg <= 2'b00;
            sm_reg <= 2'b00;
            burst_reg <= 1'b0;
            wctl_reg <= `TCD_WCTL_RST;
        end else begin
            if (w_mode) begin
                dm_reg <= io_wdata[`TCD_MD_DM+1:`TCD_MD_DM];
                sm_reg <= io_wdata[`TCD_MD_SM+1:`TCD_MD_SM];
                burst_reg <= io_wdata[`TCD_MD_BURST];
            end
            if (w_wctl)
                wctl_reg <= io_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read-back and interrupt lines

    wire [7:0] stat_rd = {en_reg, 2'b11, ie_reg, 1'b0, dme_reg};
    wire [7:0] mode_rd = {2'b00, dm_reg, sm_reg, burst_reg, 1'b0};
    wire [`TCD_AW-1:0] rd_wide =
        hit_sar ? sar_reg >> {off_sar[1:0], 3'b000} :
        hit_dar ? dar_reg >> {off_dar[1:0], 3'b000} :
        hit_mar ? mar_reg >> {off_mar[1:0], 3'b000} :
        hit_iar ? iar_ext >> {off_iar[1:0], 3'b000} :
        hit_bc0 ? bc0_ext >> {off_bc0[1:0], 3'b000} :
        hit_bc1 ? bc1_ext >> {off_bc1[1:0], 3'b000} : '0;
    wire [7:0] rd_mux =
        hit_stat ? stat_rd :
        hit_mode ? mode_rd :
        hit_wctl ? wctl_reg : rd_wide[7:0];

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= 8'h00;
            irq_reg <= 2'b00;
        end else begin
            if (io_rd)
                rdata_reg <= rd_mux;
            irq_reg <= ~en_reg & ie_reg;
        end
    end

    assign io_rdata = rdata_reg;
    assign bus_out = bus_reg;
    assign bus_hold = hold_reg;
    assign tend0_n = tend_n_reg;
    assign irq = irq_reg;

endmodule

//--- verilog/tcd_pkg.sv
// Types shared by the two-channel DMA register block
`include "tcd_defs.svh"
package tcd_pkg;

    typedef enum logic [1:0] {
        TCD_IDLE = 2'b00,
        TCD_READ = 2'b01,
        TCD_WRITE = 2'b11
    } tcd_state_t;

    typedef struct packed {
        logic [`TCD_AW-1:0] addr;
        logic is_io;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } tcd_bus_t;

endpackage
